// File: logic/pts_defines.vh
// constants for the timestamp stream adapter: register map, fields, resets
// assumes inclusion by every logic file of the adapter, nothing else
`ifndef PTS_DEFINES_VH
`define PTS_DEFINES_VH

// avalon byte addresses, one 32-bit word each
`define PTS_ADDR_CTRL      4'h0
`define PTS_ADDR_TX_LAT    4'h4
`define PTS_ADDR_RX_LAT    4'h8
`define PTS_ADDR_STATUS    4'hc

// control register fields
`define PTS_CTRL_TX_INLINE 0
`define PTS_CTRL_RX_INLINE 1
`define PTS_CTRL_FMT_CF    2
`define PTS_CTRL_RST       3'h0

// latency adjust in nanoseconds, reset to the full fixed path latency
`define PTS_TX_LAT_RST     16'h0040
`define PTS_RX_LAT_RST     16'h0030

// command field layout
`define PTS_CMD_OP_LO      0
`define PTS_CMD_CSUM_BIT   8
`define PTS_CMD_TAG_LO     16
`define PTS_OP_NONE        2'h0
`define PTS_OP_ONE_STEP    2'h1
`define PTS_OP_TWO_STEP    2'h2

// widened transmit user bits
`define PTS_USER_UNDERRUN  0
`define PTS_USER_CMD_LO    64

// in-line words are eight byte beats long
`define PTS_INLINE_BEATS   4'h8
// receive delay: eight stamp beats plus the beat that shows the frame start
`define PTS_RX_DLY_STAGES  9
`define PTS_NS_PER_SEC     33'h03b9aca00

`endif

// File: logic/pts_delay_line.v
// fixed delay line used ahead of the receive in-line insert
// assumes a continuous byte stream, one beat per clock
`timescale 1ns/100ps
`default_nettype none
`include "pts_defines.vh"

module pts_delay_line #(
  parameter W = 11
) (
  input  wire         clock,
  input  wire         rst_b,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  // one stage more than the stamp, else the first frame beat is lost
  reg [W-1:0] stage_q [0:`PTS_RX_DLY_STAGES-1];

  genvar i;
  generate
    for (i = 0; i < `PTS_RX_DLY_STAGES; i = i + 1) begin : g_stage
      if (i == 0) begin : g_head
        always @(posedge clock) begin
          if (!rst_b) begin
            stage_q[i] <= {W{1'b0}};
          end else begin
            stage_q[i] <= din;
          end
        end
      end else begin : g_tail
        always @(posedge clock) begin
          if (!rst_b) begin
            stage_q[i] <= {W{1'b0}};
          end else begin
            stage_q[i] <= stage_q[i-1];
          end
        end
      end
    end
  endgenerate

  assign dout = stage_q[`PTS_RX_DLY_STAGES-1];

endmodule

`default_nettype wire

// File: logic/pts_lat_adj.v
// captures the timer and adds or subtracts a latency, one cycle later valid
// assumes timer inputs are steady in the cycle of the take pulse
`timescale 1ns/100ps
`default_nettype none
`include "pts_defines.vh"

module pts_lat_adj (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        take,
  input  wire        sub,
  input  wire [47:0] sec_i,
  input  wire [31:0] ns_i,
  input  wire [63:0] cf_i,
  input  wire [15:0] lat_i,
  output reg  [79:0] tod_q,
  output reg  [63:0] cf_q,
  output reg         done_q
);

  reg [32:0] ns_sum;
  reg [32:0] ns_d;
  reg [47:0] sec_d;

  always @* begin
    ns_sum = {1'b0, ns_i} + {17'h0, lat_i};
    ns_d   = ns_sum;
    sec_d  = sec_i;
    if (sub) begin
      if (ns_i >= {16'h0, lat_i}) begin
        ns_d = {1'b0, ns_i} - {17'h0, lat_i};
      end else begin
        // borrow a second so nanoseconds stay in range
        ns_d  = {1'b0, ns_i} + `PTS_NS_PER_SEC - {17'h0, lat_i};
        sec_d = sec_i - 48'h1;
      end
    end else if (ns_sum >= `PTS_NS_PER_SEC) begin
      ns_d  = ns_sum - `PTS_NS_PER_SEC;
      sec_d = sec_i + 48'h1;
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      tod_q  <= 80'h0;
      cf_q   <= 64'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= take;
      if (take) begin
        tod_q <= {sec_d, ns_d[31:0]};
        // scaled nanoseconds: latency sits above the 16 fraction bits
        if (sub) begin
          cf_q <= cf_i - {32'h0, lat_i, 16'h0};
        end else begin
          cf_q <= cf_i + {32'h0, lat_i, 16'h0};
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: logic/pts_adapter.v
// timestamp stream adapter between client streams and a gigabit mac path
// assumes byte-wide streams, a free-running timer and an avalon master
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "pts_defines.vh"

module pts_adapter (
  input  wire         clock,
  input  wire         rst_b,
  // avalon-mm register slave
  input  wire [3:0]   avs_address,
  input  wire         avs_read,
  input  wire         avs_write,
  input  wire [31:0]  avs_writedata,
  output reg  [31:0]  avs_readdata,
  output reg          avs_waitrequest,
  // timer
  input  wire [47:0]  time_of_day_sec,
  input  wire [31:0]  time_of_day_ns,
  input  wire [63:0]  cf_time,
  // transmit from client
  input  wire [7:0]   tx_in_data,
  input  wire         tx_in_valid,
  input  wire         tx_in_last,
  input  wire [127:0] tx_in_user,
  output reg          tx_in_ready,
  // transmit to mac
  output reg  [7:0]   tx_mac_data,
  output reg          tx_mac_valid,
  output reg          tx_mac_last,
  output reg          tx_mac_underrun,
  output reg          tx_mac_recalc_fcs,
  output reg          tx_mac_recalc_udp,
  input  wire         tx_mac_ready,
  // transmit timestamp stream
  output reg  [79:0]  tx_timestamp_stream_data,
  output reg  [15:0]  tx_timestamp_stream_tag,
  output reg          tx_timestamp_stream_valid,
  input  wire         tx_timestamp_stream_ready,
  // receive from phy/mac
  input  wire         rx_in_sfd,
  input  wire [7:0]   rx_in_data,
  input  wire         rx_in_valid,
  input  wire         rx_in_last,
  input  wire         rx_in_user,
  // receive to client
  output reg  [7:0]   rx_out_data,
  output reg          rx_out_valid,
  output reg          rx_out_last,
  output reg          rx_out_user,
  // receive timestamp stream
  output reg  [79:0]  rx_timestamp_stream_data,
  output reg          rx_timestamp_stream_valid
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_CMD   = 2'h1;
  localparam ST_FRAME = 2'h2;

  reg  [2:0]  ctrl_q;
  reg  [15:0] tx_lat_q;
  reg  [15:0] rx_lat_q;
  reg  [15:0] tx_cnt_q;
  reg  [15:0] rx_cnt_q;
  reg  [1:0]  st_q;
  reg  [1:0]  st_d;
  reg  [3:0]  cmd_cnt_q;
  reg  [63:0] cmd_q;
  reg  [63:0] cmd_use;
  reg         rx_frame_q;
  reg  [3:0]  inj_cnt_q;
  reg  [63:0] inj_word_q;
  reg         out_valid_d;

  wire tx_inline = ctrl_q[`PTS_CTRL_TX_INLINE];
  wire rx_inline = ctrl_q[`PTS_CTRL_RX_INLINE];
  wire fmt_cf    = ctrl_q[`PTS_CTRL_FMT_CF];
  wire bus_go    = (avs_read | avs_write) & avs_waitrequest;
  wire wr_en     = avs_write & ~avs_waitrequest;
  wire tx_take   = tx_in_valid & tx_in_ready;
  wire tx_first  = tx_take & (st_q != ST_CMD) & (st_q != ST_FRAME);
  wire [1:0] op  = cmd_use[`PTS_CMD_OP_LO +: 2];
  wire op_stamp  = (op == `PTS_OP_ONE_STEP) | (op == `PTS_OP_TWO_STEP);
  wire rx_first  = rx_in_valid & ~rx_frame_q;

  wire [79:0] tx_tod;
  wire [63:0] tx_cf;
  wire        tx_done;
  wire [79:0] rx_tod;
  wire [63:0] rx_cf;
  wire        rx_done;
  wire [10:0] rx_dly;
  reg         tx_stamp_pend_q;
  reg  [15:0] tx_tag_q;

  // avalon slave: one wait cycle, then the answer edge
  always @(posedge clock) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      ctrl_q          <= `PTS_CTRL_RST;
      tx_lat_q        <= `PTS_TX_LAT_RST;
      rx_lat_q        <= `PTS_RX_LAT_RST;
    end else begin
      avs_waitrequest <= ~bus_go;
      if (bus_go & avs_read) begin
        case (avs_address)
          `PTS_ADDR_CTRL:   avs_readdata <= {29'h0, ctrl_q};
          `PTS_ADDR_TX_LAT: avs_readdata <= {16'h0, tx_lat_q};
          `PTS_ADDR_RX_LAT: avs_readdata <= {16'h0, rx_lat_q};
          `PTS_ADDR_STATUS: avs_readdata <= {rx_cnt_q, tx_cnt_q};
          default:          avs_readdata <= 32'h0;
        endcase
      end
      if (wr_en) begin
        case (avs_address)
          `PTS_ADDR_CTRL:   ctrl_q   <= avs_writedata[2:0];
          `PTS_ADDR_TX_LAT: tx_lat_q <= avs_writedata[15:0];
          `PTS_ADDR_RX_LAT: rx_lat_q <= avs_writedata[15:0];
          default:          ctrl_q   <= ctrl_q;
        endcase
      end
    end
  end

  // transmit sequencing: optional eight command bytes, then the frame
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (tx_take & tx_inline) begin
          st_d = ST_CMD;
        end else if (tx_take & ~tx_in_last) begin
          st_d = ST_FRAME;
        end
      end
      ST_CMD: begin
        if (tx_take & (cmd_cnt_q == `PTS_INLINE_BEATS - 4'h1)) begin
          st_d = ST_IDLE;
        end
      end
      ST_FRAME: begin
        if (tx_take & tx_in_last) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // after an in-line command the next beat is the frame's first
  reg cmd_ready_q;

  always @* begin
    if (tx_inline) begin
      cmd_use = cmd_q;
    end else begin
      cmd_use = tx_in_user[`PTS_USER_CMD_LO +: 64];
    end
  end

  wire frame_beat = tx_take & (st_q != ST_CMD) & ~(st_q == ST_IDLE &
                    tx_inline & ~cmd_ready_q);
  wire frame_first = frame_beat & (st_q == ST_IDLE);

  always @* begin
    out_valid_d = (tx_mac_valid & ~tx_mac_ready) | frame_beat;
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      st_q        <= ST_IDLE;
      cmd_cnt_q   <= 4'h0;
      cmd_q       <= 64'h0;
      cmd_ready_q <= 1'b0;
      tx_in_ready <= 1'b0;
      tx_mac_data       <= 8'h0;
      tx_mac_valid      <= 1'b0;
      tx_mac_last       <= 1'b0;
      tx_mac_underrun   <= 1'b0;
      tx_mac_recalc_fcs <= 1'b0;
      tx_mac_recalc_udp <= 1'b0;
    end else begin
      st_q <= (frame_first & ~tx_in_last) ? ST_FRAME :
              (frame_first ? ST_IDLE : st_d);
      // half rate: ready only while the single output stage is free
      tx_in_ready  <= ~out_valid_d;
      tx_mac_valid <= out_valid_d;
      if (st_q == ST_IDLE & tx_take & tx_inline & ~cmd_ready_q) begin
        cmd_q     <= {tx_in_data, cmd_q[63:8]};
        cmd_cnt_q <= 4'h1;
        st_q      <= ST_CMD;
      end else if (st_q == ST_CMD & tx_take) begin
        cmd_q     <= {tx_in_data, cmd_q[63:8]};
        cmd_cnt_q <= cmd_cnt_q + 4'h1;
        if (cmd_cnt_q == `PTS_INLINE_BEATS - 4'h1) begin
          cmd_ready_q <= 1'b1;
        end
      end
      if (frame_first) begin
        cmd_ready_q <= 1'b0;
        tx_mac_recalc_fcs <= (op == `PTS_OP_ONE_STEP);
        tx_mac_recalc_udp <= (op == `PTS_OP_ONE_STEP) &
                             cmd_use[`PTS_CMD_CSUM_BIT];
      end
      if (frame_beat) begin
        tx_mac_data     <= tx_in_data;
        tx_mac_last     <= tx_in_last;
        tx_mac_underrun <= tx_in_user[`PTS_USER_UNDERRUN];
      end
    end
  end

  // capture at pipeline entry; only fixed stages follow
  pts_lat_adj u_tx_adj (
    .clock  (clock),
    .rst_b  (rst_b),
    .take   (frame_first),
    .sub    (1'b0),
    .sec_i  (time_of_day_sec),
    .ns_i   (time_of_day_ns),
    .cf_i   (cf_time),
    .lat_i  (tx_lat_q),
    .tod_q  (tx_tod),
    .cf_q   (tx_cf),
    .done_q (tx_done)
  );

  // transmit stamp return, held until taken
  always @(posedge clock) begin
    if (!rst_b) begin
      tx_stamp_pend_q           <= 1'b0;
      tx_tag_q                  <= 16'h0;
      tx_timestamp_stream_valid <= 1'b0;
      tx_timestamp_stream_data  <= 80'h0;
      tx_timestamp_stream_tag   <= 16'h0;
      tx_cnt_q                  <= 16'h0;
    end else begin
      if (frame_first) begin
        tx_stamp_pend_q <= op_stamp;
        tx_tag_q        <= cmd_use[`PTS_CMD_TAG_LO +: 16];
        tx_cnt_q        <= tx_cnt_q + 16'h1;
      end
      if (tx_done & tx_stamp_pend_q) begin
        tx_timestamp_stream_valid <= 1'b1;
        tx_timestamp_stream_tag   <= tx_tag_q;
        tx_timestamp_stream_data  <= fmt_cf ? {16'h0, tx_cf} : tx_tod;
      end else if (tx_timestamp_stream_ready) begin
        tx_timestamp_stream_valid <= 1'b0;
      end
    end
  end

  pts_lat_adj u_rx_adj (
    .clock  (clock),
    .rst_b  (rst_b),
    .take   (rx_in_sfd),
    .sub    (1'b1),
    .sec_i  (time_of_day_sec),
    .ns_i   (time_of_day_ns),
    .cf_i   (cf_time),
    .lat_i  (rx_lat_q),
    .tod_q  (rx_tod),
    .cf_q   (rx_cf),
    .done_q (rx_done)
  );

  pts_delay_line #(
    .W (11)
  ) u_rx_dly (
    .clock (clock),
    .rst_b (rst_b),
    .din   ({rx_in_valid, rx_in_last, rx_in_user, rx_in_data}),
    .dout  (rx_dly)
  );

  always @(posedge clock) begin
    if (!rst_b) begin
      rx_frame_q                <= 1'b0;
      inj_cnt_q                 <= 4'h0;
      inj_word_q                <= 64'h0;
      rx_out_data               <= 8'h0;
      rx_out_valid              <= 1'b0;
      rx_out_last               <= 1'b0;
      rx_out_user               <= 1'b0;
      rx_timestamp_stream_valid <= 1'b0;
      rx_timestamp_stream_data  <= 80'h0;
      rx_cnt_q                  <= 16'h0;
    end else begin
      if (rx_in_valid) begin
        rx_frame_q <= ~rx_in_last;
      end
      // every frame gets its sideband stamp
      rx_timestamp_stream_valid <= rx_done;
      if (rx_done) begin
        rx_timestamp_stream_data <= fmt_cf ? {16'h0, rx_cf} : rx_tod;
        rx_cnt_q                 <= rx_cnt_q + 16'h1;
      end
      if (rx_first & rx_inline) begin
        inj_cnt_q <= `PTS_INLINE_BEATS;
        inj_word_q <= fmt_cf ? rx_cf : {rx_tod[63:32], rx_tod[31:0]};
      end else if (inj_cnt_q != 4'h0) begin
        inj_cnt_q  <= inj_cnt_q - 4'h1;
        inj_word_q <= {8'h0, inj_word_q[63:8]};
      end
      if (inj_cnt_q != 4'h0) begin
        // stamp bytes fill eight of the nine cycles the frame is held back
        rx_out_valid <= 1'b1;
        rx_out_data  <= inj_word_q[7:0];
        rx_out_last  <= 1'b0;
        rx_out_user  <= 1'b0;
      end else if (rx_inline) begin
        rx_out_valid <= rx_dly[10];
        rx_out_last  <= rx_dly[9];
        rx_out_user  <= rx_dly[8];
        rx_out_data  <= rx_dly[7:0];
      end else begin
        rx_out_valid <= rx_in_valid;
        rx_out_last  <= rx_in_last;
        rx_out_user  <= rx_in_user;
        rx_out_data  <= rx_in_data;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/pts_adapter_sva.sv
// checker for the timestamp adapter, sees the top ports only
// assumes the control word is written at address 0 over avalon
`timescale 1ns/100ps
`default_nettype none
module pts_adapter_chk (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  tx_in_data,
  input wire logic        tx_in_valid,
  input wire logic        tx_in_ready,
  input wire logic [7:0]  tx_mac_data,
  input wire logic        tx_mac_valid,
  input wire logic        tx_mac_ready,
  input wire logic        tx_mac_recalc_fcs,
  input wire logic        tx_mac_recalc_udp,
  input wire logic [79:0] tx_timestamp_stream_data,
  input wire logic        tx_timestamp_stream_valid,
  input wire logic        tx_timestamp_stream_ready,
  input wire logic        rx_in_sfd,
  input wire logic [7:0]  rx_in_data,
  input wire logic        rx_in_valid,
  input wire logic [7:0]  rx_out_data,
  input wire logic        rx_out_valid,
  input wire logic        rx_timestamp_stream_valid
);
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  // mirror of the control word, taken where the write lands
  always_comb begin
    ctrl_d = ctrl_q;
    if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
      ctrl_d = avs_writedata[2:0];
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence stamp_sq; rx_out_valid [*8]; endsequence
  sequence first_sq; rx_in_valid && !$past(rx_in_valid); endsequence
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  bus_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest
    && $past(avs_read || avs_write, 2)) else $error("bus answer wrong");
  rx_stamp_a: assert property (rx_in_sfd |-> ##2 rx_timestamp_stream_valid)
    else $error("receive stamp missing");
  rx_once_a: assert property (rx_timestamp_stream_valid |->
    $past(rx_in_sfd, 2) ##1 !rx_timestamp_stream_valid)
    else $error("receive stamp without delimiter");
  rx_plain_a: assert property (!ctrl_q[1] && rx_in_valid |=> rx_out_valid
    && rx_out_data == $past(rx_in_data)) else $error("plain receive bad");
  rx_inline_a: assert property ((ctrl_q[1] and first_sq) |->
    ##2 stamp_sq ##1 rx_out_data == $past(rx_in_data, 10))
    else $error("inline receive bad");
  tx_half_a: assert property (!ctrl_q[0] && tx_in_valid && tx_in_ready
    |=> !tx_in_ready) else $error("transmit ready not dropped");
  tx_pass_a: assert property (!ctrl_q[0] && tx_in_valid && tx_in_ready
    |=> tx_mac_valid && tx_mac_data == $past(tx_in_data))
    else $error("transmit beat not passed");
  tx_hold_a: assert property (tx_mac_valid && !tx_mac_ready |=> tx_mac_valid
    && $stable(tx_mac_data)) else $error("mac beat dropped");
  ts_hold_a: assert property (tx_timestamp_stream_valid
    && !tx_timestamp_stream_ready |=> tx_timestamp_stream_valid
    && $stable(tx_timestamp_stream_data)) else $error("stamp dropped");
  udp_fcs_a: assert property (tx_mac_recalc_udp |-> tx_mac_recalc_fcs)
    else $error("checksum without fcs");
endmodule
`default_nettype wire

// File: tb/pts_stamp_sink.sv
// client side consumer of transmit stamps
// assumes stamp valid holds until ready; slow stalls every other cycle
`timescale 1ns/100ps
`default_nettype none
module pts_stamp_sink (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic [79:0] tx_timestamp_stream_data,
  input  wire logic [15:0] tx_timestamp_stream_tag,
  input  wire logic        tx_timestamp_stream_valid,
  output var  logic        tx_timestamp_stream_ready,
  output var  logic [79:0] got_data,
  output var  logic [15:0] got_tag,
  output var  logic [31:0] got_cnt
);
  always @(posedge clock) begin
    if (!rst_b) begin
      tx_timestamp_stream_ready <= 1'b0;
      got_data <= 80'h0;
      got_tag <= 16'h0;
      got_cnt <= 32'h0;
    end else begin
      tx_timestamp_stream_ready <= !slow || !tx_timestamp_stream_ready;
      if (tx_timestamp_stream_valid && tx_timestamp_stream_ready) begin
        got_data <= tx_timestamp_stream_data;
        got_tag <= tx_timestamp_stream_tag;
        got_cnt <= got_cnt + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/pts_adapter_tb.sv
// self-checking bench for the timestamp stream adapter
// assumes checker and stamp sink are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module pts_adapter_tb;
  logic         clock, rst_b, slow, avs_read, avs_write, avs_waitrequest;
  logic [3:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, rd, time_of_day_ns, got_cnt;
  logic [47:0]  time_of_day_sec;
  logic [63:0]  cf_time;
  logic [7:0]   tx_in_data, tx_mac_data, rx_in_data, rx_out_data;
  logic [127:0] tx_in_user;
  logic         tx_in_valid, tx_in_last, tx_in_ready, tx_mac_valid;
  logic         tx_mac_last, tx_mac_underrun, tx_mac_recalc_fcs;
  logic         tx_mac_recalc_udp, tx_mac_ready, tx_timestamp_stream_valid;
  logic         tx_timestamp_stream_ready, rx_in_sfd, rx_in_valid;
  logic         rx_in_last, rx_in_user, rx_out_valid, rx_out_last;
  logic         rx_out_user, rx_timestamp_stream_valid;
  logic         und_seen, fcs_seen, udp_seen;
  logic [79:0]  tx_timestamp_stream_data, rx_timestamp_stream_data;
  logic [79:0]  got_data, rx_stamp;
  logic [15:0]  tx_timestamp_stream_tag, got_tag;
  logic [7:0]   tx_q[$];
  logic [7:0]   rx_q[$];
  int           num_errors, checks_done, rx_cnt, i, tx_last_pos, rx_last_pos;

  pts_adapter u_pts_adapter (.clock, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .time_of_day_sec, .time_of_day_ns, .cf_time, .tx_in_data, .tx_in_valid,
    .tx_in_last, .tx_in_user, .tx_in_ready, .tx_mac_data, .tx_mac_valid,
    .tx_mac_last, .tx_mac_underrun, .tx_mac_recalc_fcs, .tx_mac_recalc_udp,
    .tx_mac_ready, .tx_timestamp_stream_data, .tx_timestamp_stream_tag,
    .tx_timestamp_stream_valid, .tx_timestamp_stream_ready, .rx_in_sfd,
    .rx_in_data, .rx_in_valid, .rx_in_last, .rx_in_user, .rx_out_data,
    .rx_out_valid, .rx_out_last, .rx_out_user, .rx_timestamp_stream_data,
    .rx_timestamp_stream_valid);
  pts_stamp_sink u_pts_stamp_sink (.clock, .rst_b, .slow,
    .tx_timestamp_stream_data, .tx_timestamp_stream_tag,
    .tx_timestamp_stream_valid, .tx_timestamp_stream_ready, .got_data,
    .got_tag, .got_cnt);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // mac side stalls every other cycle
  always @(posedge clock) tx_mac_ready <= !tx_mac_ready;
  always @(posedge clock) begin
    if (tx_mac_valid && tx_mac_ready) begin
      tx_q.push_back(tx_mac_data);
      if (tx_mac_last) tx_last_pos = tx_q.size();
      und_seen = und_seen | tx_mac_underrun;
      fcs_seen = tx_mac_recalc_fcs;
      udp_seen = tx_mac_recalc_udp;
    end
    if (rx_out_valid) rx_q.push_back(rx_out_data);
    if (rx_out_valid && rx_out_last) rx_last_pos = rx_q.size();
    if (rx_timestamp_stream_valid) begin
      rx_stamp = rx_timestamp_stream_data;
      rx_cnt = rx_cnt + 1;
    end
  end

  // nanoseconds wrap at one second in either direction
  function automatic logic [79:0] tod_adj(input logic [47:0] s,
    input logic [31:0] n, input logic [15:0] l, input logic sub);
    logic [32:0] t;
    t = sub ? {1'b0, n} - l : {1'b0, n} + l;
    if (sub && t[32]) return {s - 48'h1, t[31:0] + 32'h3b9aca00};
    if (!sub && t >= 33'h03b9aca00) return {s + 48'h1, t[31:0] - 32'h3b9aca00};
    return {s, t[31:0]};
  endfunction
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic tx_beat(input logic [7:0] d, input logic l, input logic [127:0] u);
    tx_in_data <= d;
    tx_in_last <= l;
    tx_in_user <= u;
    tx_in_valid <= 1'b1;
    @(posedge clock);
    while (tx_in_ready !== 1'b1) @(posedge clock);
  endtask
  // in-line mode puts the inverse command on the user bits as bait
  task automatic tx_run(input logic [63:0] c, input logic inl, input logic [15:0] l);
    int j;
    int c0;
    logic [127:0] u;
    c0 = got_cnt;
    u = {inl ? ~c : c, 63'h2aaa_aaaa_aaaa_aaaa, c[0]};
    tx_q.delete();
    tx_last_pos = 0;
    und_seen = 1'b0;
    @(posedge clock);
    if (inl) for (j = 0; j < 8; j++) tx_beat(c[8*j +: 8], 1'b0, u);
    for (j = 0; j < 6; j++) tx_beat(8'h10 + j[7:0], j == 5, u);
    tx_in_valid <= 1'b0;
    tx_in_last <= 1'b0;
    repeat (16) @(posedge clock);
    chk(tx_q.size(), 6);
    chk(tx_last_pos, 6);
    for (j = 0; j < tx_q.size(); j++) chk(tx_q[j], 8'h10 + j[7:0]);
    chk(und_seen, c[0]);
    chk(fcs_seen, c[1:0] == 2'b01);
    chk(udp_seen, c[1:0] == 2'b01 && c[8]);
    chk(got_cnt, c0 + ((c[1] ^ c[0]) ? 1 : 0));
    if (c[1] ^ c[0]) begin
      chk(got_tag, c[31:16]);
      chk(got_data, tod_adj(time_of_day_sec, time_of_day_ns, l, 1'b0));
    end
  endtask
  task automatic rx_run(input logic inl, input logic [79:0] e);
    int j;
    int c0;
    c0 = rx_cnt;
    rx_q.delete();
    rx_last_pos = 0;
    @(posedge clock);
    rx_in_sfd <= 1'b1;
    @(posedge clock);
    rx_in_sfd <= 1'b0;
    @(posedge clock);
    for (j = 0; j < 6; j++) begin
      rx_in_data <= 8'h20 + j[7:0];
      rx_in_valid <= 1'b1;
      rx_in_last <= (j == 5);
      @(posedge clock);
    end
    rx_in_valid <= 1'b0;
    rx_in_last <= 1'b0;
    repeat (16) @(posedge clock);
    chk(rx_cnt, c0 + 1);
    chk(rx_stamp, e);
    chk(rx_q.size(), inl ? 14 : 6);
    chk(rx_last_pos, inl ? 14 : 6);
    for (j = 0; j < rx_q.size(); j++) begin
      if (inl && j < 8) chk(rx_q[j], e[8*j +: 8]);
      else chk(rx_q[j], 8'h20 + j[7:0] - (inl ? 8'h8 : 8'h0));
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {rst_b, avs_read, avs_write, tx_in_valid, tx_in_last} = 5'h0;
    {rx_in_sfd, rx_in_valid, rx_in_last, rx_in_user, tx_mac_ready} = 5'h0;
    {avs_address, avs_writedata, tx_in_data, tx_in_user, rx_in_data} = '0;
    slow = 1'b1;
    time_of_day_sec = 48'h0000_1234_5678;
    time_of_day_ns = 32'h3b9ac9f0;
    cf_time = 64'h0000_1234_0056_0000;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h4, 32'h40);
    rd_chk(4'h8, 32'h30);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    rd_chk(4'h2, 32'h0);
    rd_chk(4'h0, 32'h0);
    for (i = 0; i < 4; i++) begin
      tx_run({32'h0, 16'ha000 + i[15:0], 16'h0100 + i[15:0]}, 1'b0, 16'h40);
    end
    slow <= 1'b0;
    bus(1'b1, 4'h4, 32'h5);
    bus(1'b1, 4'h0, 32'h1);
    rd_chk(4'h0, 32'h1);
    tx_run(64'h0000_0000_b00b_0002, 1'b1, 16'h5);
    bus(1'b1, 4'h0, 32'h0);
    rx_run(1'b0, tod_adj(time_of_day_sec, time_of_day_ns, 16'h30, 1'b1));
    time_of_day_ns <= 32'h10;
    bus(1'b1, 4'h0, 32'h2);
    rx_run(1'b1, tod_adj(time_of_day_sec, 32'h10, 16'h30, 1'b1));
    bus(1'b1, 4'h0, 32'h6);
    rx_run(1'b1, {16'h0, cf_time - 64'h30_0000});
    rd_chk(4'hc, 32'h0003_0005);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule
bind pts_adapter pts_adapter_chk u_pts_adapter_chk (.clock, .rst_b,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
  .tx_in_data, .tx_in_valid, .tx_in_ready, .tx_mac_data, .tx_mac_valid,
  .tx_mac_ready, .tx_mac_recalc_fcs, .tx_mac_recalc_udp,
  .tx_timestamp_stream_data, .tx_timestamp_stream_valid,
  .tx_timestamp_stream_ready, .rx_in_sfd, .rx_in_data, .rx_in_valid,
  .rx_out_data, .rx_out_valid, .rx_timestamp_stream_valid);
`default_nettype wire
